// ==== design/hrcc_regs.svh ====
`ifndef HRCC_REGS_SVH
`define HRCC_REGS_SVH

// ****************************************
// Timing
// ****************************************
`define HRCC_CLK_PERIOD_NS     20
`define HRCC_CPU_HOLD_NS       1000000
`define HRCC_CPU_HOLD_CYC      (`HRCC_CPU_HOLD_NS / `HRCC_CLK_PERIOD_NS)
`define HRCC_CORE_REL_MIN_CYC  4
`define HRCC_CORE_REL_MAX_CYC  6
`define HRCC_CORE_REL_CYC      4
`define HRCC_NUM_CPU_BUSES     2
`define HRCC_NUM_PORTS         4

// ****************************************
// Sleep states
// ****************************************
`define HRCC_SLP_S0  3'h0
`define HRCC_SLP_S1  3'h1
`define HRCC_SLP_S2  3'h2
`define HRCC_SLP_S3  3'h3
`define HRCC_SLP_S4  3'h4
`define HRCC_SLP_S5  3'h5

`endif

// ==== design/hrcc_pkg.sv ====
package hrcc_pkg;

	typedef enum logic [1:0] {
		HRCC_OFF    = 2'b00,
		HRCC_HARD   = 2'b01,
		HRCC_CPUHLD = 2'b11,
		HRCC_RUN    = 2'b10
	} hrcc_state_t;

endpackage

// ==== design/hrcc_sync_if.sv ====
`timescale 1ns/1ps
interface hrcc_sync_if;
	logic clk;
	logic pg_raw;
	logic pg_sync;
	logic pg_rst;
	modport src (output clk, output pg_raw, input pg_sync, input pg_rst);
	modport snk (input clk, input pg_raw, output pg_sync, output pg_rst);
endinterface

// ==== design/hrcc_pg_sync.sv ====
`timescale 1ns/1ps
// ****************************************
// Power-good synchroniser
// ****************************************
// Asserts reset as soon as power-good falls, releases it through two flops.
module hrcc_pg_sync (
	hrcc_sync_if.snk s
);
	logic s1_q;
	logic s2_q;

	always_ff @(posedge s.clk or negedge s.pg_raw) begin
		if (!s.pg_raw) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
		end else begin
			s1_q <= 1'b1;
			s2_q <= s1_q;
		end
	end

	assign s.pg_sync = s2_q;
	assign s.pg_rst  = ~s2_q;
endmodule

// ==== design/hrcc_top.sv ====
`timescale 1ns/1ps
`include "hrcc_regs.svh"
module hrcc_top #(
	parameter int CPU_HOLD_CYC = `HRCC_CPU_HOLD_CYC,
	parameter int NPORT        = `HRCC_NUM_PORTS,
	parameter int NCPU         = `HRCC_NUM_CPU_BUSES
) (
	input  wire logic             core_clk_in,
	input  wire logic             srst_in,
	input  wire logic             power_good_in,
	input  wire logic             hard_reset_in_n,
	input  wire logic             cfg_hard_req_in,
	input  wire logic             cfg_cpu_req_in,
	input  wire logic [NPORT-1:0] cfg_port_req_in,
	input  wire logic             bus_init_n_in,
	input  wire logic             err_event_in,
	input  wire logic [2:0]       sleep_req_in,
	input  wire logic             sleep_req_valid_in,
	output logic      [NCPU-1:0]  cpu_bus_reset_out_n,
	output logic                  core_reset_out,
	output logic                  hard_reset_out,
	output logic      [NPORT-1:0] port_reset_out,
	output logic      [NPORT-1:0] link_train_en_out,
	output logic                  in_order_queue_clr_out,
	output logic                  bus_sm_reset_out,
	output logic                  refresh_en_out,
	output logic                  bus_init_n_seen_out,
	output logic                  sticky_err_out,
	output logic      [2:0]       sleep_state_out,
	output logic                  sleep_reject_out,
	output logic                  outputs_safe_out
);
	// ****************************************
	// Power-good synchronisation
	// ****************************************
	hrcc_sync_if sif ();
	assign sif.clk    = core_clk_in;
	assign sif.pg_raw = power_good_in;
	hrcc_pg_sync u_sync (.s(sif));

	logic pg_ok;
	logic pg_rst;
	assign pg_ok  = sif.pg_sync;
	assign pg_rst = sif.pg_rst | srst_in;

	// Hard-reset input through two flops; flop 1 feeds only flop 2.
	logic hr1_q;
	logic hr2_q;
	always_ff @(posedge core_clk_in or posedge pg_rst) begin
		if (pg_rst) begin
			hr1_q <= 1'b1;
			hr2_q <= 1'b1;
		end else begin
			hr1_q <= ~hard_reset_in_n;
			hr2_q <= hr1_q;
		end
	end

	logic hard_cause;
	assign hard_cause = hr2_q | cfg_hard_req_in;

	// ****************************************
	// Reset sequencer
	// ****************************************
	hrcc_pkg::hrcc_state_t state_q;
	logic [2:0]            rel_cnt_q;
	logic [31:0]           hold_cnt_q;

	always_ff @(posedge core_clk_in or posedge pg_rst) begin
		if (pg_rst) begin
			state_q <= hrcc_pkg::HRCC_OFF;
		end else if (hard_cause) begin
			state_q <= hrcc_pkg::HRCC_HARD;
		end else begin
			unique case (state_q)
				hrcc_pkg::HRCC_OFF: begin
					state_q <= hrcc_pkg::HRCC_HARD;
				end
				hrcc_pkg::HRCC_HARD: begin
					if (rel_cnt_q == 3'(`HRCC_CORE_REL_CYC - 2)) begin
						state_q <= hrcc_pkg::HRCC_CPUHLD;
					end
				end
				hrcc_pkg::HRCC_CPUHLD: begin
					if (hold_cnt_q >= 32'(CPU_HOLD_CYC - 1)) begin
						state_q <= hrcc_pkg::HRCC_RUN;
					end
				end
				hrcc_pkg::HRCC_RUN: begin
					state_q <= hrcc_pkg::HRCC_RUN;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (pg_rst || hard_cause || state_q != hrcc_pkg::HRCC_HARD) begin
			rel_cnt_q <= 3'h0;
		end else begin
			rel_cnt_q <= rel_cnt_q + 3'h1;
		end
	end

	// Hold timer counts from the hard-reset input release.
	always_ff @(posedge core_clk_in) begin
		if (pg_rst || hard_cause || state_q == hrcc_pkg::HRCC_OFF) begin
			hold_cnt_q <= 32'h0000_0000;
		end else if (state_q != hrcc_pkg::HRCC_RUN) begin
			hold_cnt_q <= hold_cnt_q + 32'h0000_0001;
		end
	end

	logic in_hard;
	assign in_hard = (state_q == hrcc_pkg::HRCC_OFF) || (state_q == hrcc_pkg::HRCC_HARD);

	// ****************************************
	// Processor-only and targeted requests
	// ****************************************
	logic             cpu_only_q;
	logic [NPORT-1:0] port_rst_q;
	always_ff @(posedge core_clk_in) begin
		if (pg_rst || in_hard) begin
			cpu_only_q <= 1'b0;
			port_rst_q <= '0;
		end else begin
			cpu_only_q <= cfg_cpu_req_in;
			port_rst_q <= cfg_port_req_in;
		end
	end

	// ****************************************
	// Bus-init handling
	// ****************************************
	logic bus_init_n_q;
	logic bus_init_n_seen_q;
	always_ff @(posedge core_clk_in) begin
		if (pg_rst || in_hard) begin
			bus_init_n_q      <= 1'b0;
			bus_init_n_seen_q <= 1'b0;
		end else begin
			bus_init_n_q <= ~bus_init_n_in;
			if (!bus_init_n_in) begin
				bus_init_n_seen_q <= 1'b1;
			end
		end
	end

	// Sticky error status is cleared only by power-good loss or srst_in; clear wins over set.
	logic sticky_q;
	always_ff @(posedge core_clk_in or posedge pg_rst) begin
		if (pg_rst) begin
			sticky_q <= 1'b0;
		end else if (err_event_in) begin
			sticky_q <= 1'b1;
		end
	end

	// ****************************************
	// Sleep state
	// ****************************************
	function automatic logic slp_ok(input logic [2:0] s);
		slp_ok = (s <= `HRCC_SLP_S5) && (s != `HRCC_SLP_S2);
	endfunction

	logic [2:0] slp_q;
	logic       slp_rej_q;
	always_ff @(posedge core_clk_in) begin
		if (pg_rst || in_hard) begin
			slp_q     <= `HRCC_SLP_S0;
			slp_rej_q <= 1'b0;
		end else if (sleep_req_valid_in) begin
			slp_rej_q <= ~slp_ok(sleep_req_in);
			if (slp_ok(sleep_req_in)) begin
				slp_q <= sleep_req_in;
			end
		end else begin
			slp_rej_q <= 1'b0;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	logic run;
	assign run = (state_q == hrcc_pkg::HRCC_RUN);

	always_ff @(posedge core_clk_in) begin
		if (pg_rst) begin
			cpu_bus_reset_out_n <= '0;
			core_reset_out      <= 1'b1;
			hard_reset_out      <= 1'b1;
			port_reset_out      <= '1;
			link_train_en_out   <= '0;
			outputs_safe_out    <= 1'b1;
		end else begin
			cpu_bus_reset_out_n <= {NCPU{run & ~cpu_only_q & ~hard_cause}};
			core_reset_out      <= in_hard | hard_cause;
			hard_reset_out      <= in_hard | hard_cause;
			port_reset_out      <= {NPORT{in_hard | hard_cause}} | port_rst_q;
			link_train_en_out   <= {NPORT{pg_ok & ~in_hard & ~hard_cause}} & ~port_rst_q;
			outputs_safe_out    <= in_hard | hard_cause;
		end
	end

	assign in_order_queue_clr_out = bus_init_n_q;
	assign bus_sm_reset_out       = bus_init_n_q;
	assign refresh_en_out         = ~in_hard;
	assign bus_init_n_seen_out         = bus_init_n_seen_q;
	assign sticky_err_out         = sticky_q;
	assign sleep_state_out        = slp_q;
	assign sleep_reject_out       = slp_rej_q;
endmodule

// ==== bench/hrcc_asserts.sv ====
`timescale 1ns/1ps
module hrcc_asserts #(
	parameter int CPU_HOLD_CYC = 20,
	parameter int NPORT        = 4,
	parameter int NCPU         = 2
) (
	input wire logic             core_clk_in,
	input wire logic             srst_in,
	input wire logic             power_good_in,
	input wire logic             hard_reset_in_n,
	input wire logic [NCPU-1:0]  cpu_bus_reset_out_n,
	input wire logic             core_reset_out,
	input wire logic             hard_reset_out,
	input wire logic [NPORT-1:0] port_reset_out,
	input wire logic [NPORT-1:0] link_train_en_out,
	input wire logic             sticky_err_out,
	input wire logic             outputs_safe_out
);
	default clocking @(posedge core_clk_in);
	endclocking
	default disable iff (srst_in);
	pg_low_hold_a: assert property (!power_good_in |=> core_reset_out && hard_reset_out)
		else $error("reset not held");
	pg_sticky_clr_a: assert property (!power_good_in |=> !sticky_err_out)
		else $error("sticky not cleared");
	sticky_keep_a: assert property (sticky_err_out ##1 power_good_in |-> sticky_err_out)
		else $error("sticky lost");
	hard_entry_a: assert property ((!hard_reset_in_n && power_good_in) [*4] |=>
		hard_reset_out && outputs_safe_out && cpu_bus_reset_out_n == '0) else $error("no hard");
	port_down_a: assert property (hard_reset_out |-> &port_reset_out && !(|link_train_en_out))
		else $error("ports up");
	release_win_a: assert property ($rose(hard_reset_in_n) && hard_reset_out |->
		##[4:7] !hard_reset_out) else $error("late release");
	early_rel_a: assert property ($fell(hard_reset_out) |-> $past(hard_reset_in_n, 4))
		else $error("early release");
	cpu_hold_a: assert property ($rose(cpu_bus_reset_out_n[0]) |->
		$past(hard_reset_in_n, CPU_HOLD_CYC)) else $error("cpu hold short");
	cover property ($rose(hard_reset_in_n) ##[4:7] $fell(hard_reset_out));
	cover property ($rose(cpu_bus_reset_out_n[0]));
	cover property (sticky_err_out ##1 hard_reset_out);
endmodule

// ==== bench/hrcc_platform.sv ====
`timescale 1ns/1ps
module hrcc_platform #(
	parameter int PG_DLY  = 40,
	parameter int HUB_DLY = 20
) (
	input  wire logic core_clk_in,
	input  wire logic supply_ok_in,
	input  wire logic hub_rst_req_in,
	output logic      power_good_out,
	output logic      hub_reset_out_n
);
	int cnt_q;
	always_ff @(posedge core_clk_in) begin
		if (!supply_ok_in) begin
			cnt_q <= 0;
		end else if (cnt_q < PG_DLY + HUB_DLY) begin
			cnt_q <= cnt_q + 1;
		end
	end
	assign power_good_out = supply_ok_in && cnt_q >= PG_DLY;
	assign hub_reset_out_n = cnt_q >= PG_DLY + HUB_DLY && !hub_rst_req_in;
endmodule

// ==== bench/testbench.sv ====
`timescale 1ns/1ps
module testbench;
	logic       core_clk_in = 0, srst_in = 1, power_good_in, hard_reset_in_n, supply_ok = 0;
	logic       hub_req = 0, cfg_hard_req_in = 0, cfg_cpu_req_in = 0, bus_init_n_in = 1;
	logic       err_event_in = 0, sleep_req_valid_in = 0, core_reset_out, hard_reset_out;
	logic       in_order_queue_clr_out, bus_sm_reset_out, refresh_en_out, bus_init_n_seen_out;
	logic       sticky_err_out, sleep_reject_out, outputs_safe_out;
	logic [1:0] cpu_bus_reset_out_n;
	logic [2:0] sleep_req_in = 0, sleep_state_out;
	logic [3:0] cfg_port_req_in = 0, port_reset_out, link_train_en_out;
	int         fail_count = 0, checked = 0, n;
	always #10 core_clk_in = ~core_clk_in;
	hrcc_platform i_hrcc_platform (.core_clk_in, .supply_ok_in(supply_ok), .hub_rst_req_in(hub_req),
		.power_good_out(power_good_in), .hub_reset_out_n(hard_reset_in_n));
	hrcc_top #(.CPU_HOLD_CYC(20)) i_hrcc_top (.*);
	task automatic chk(input string nm, input logic [3:0] got, input logic [3:0] exp);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic step(input int k);
		repeat (k) @(posedge core_clk_in);
		#2;
	endtask
	task automatic end_sim;
		if (fail_count == 0 && checked > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	// Times the internal and processor resets from the moment the hub lets go.
	task automatic release_chk;
		for (n = 0; hard_reset_in_n !== 1'b1 && n < 200; n++) step(1);
		for (n = 0; hard_reset_out !== 1'b0 && n < 20; n++) step(1);
		chk("release", 4'(n inside {[4:7]}), 1);
		chk("cpu_held", cpu_bus_reset_out_n, 0);
		step(2);
		chk("train", link_train_en_out, 4'hf);
		step(20);
		chk("cpu_free", cpu_bus_reset_out_n, 3);
	endtask
	initial begin
		n = $urandom(99795);
		step(10);
		srst_in = 0;
		step(1);
		chk("off", {core_reset_out, outputs_safe_out, cpu_bus_reset_out_n}, 4'hc);
		supply_ok = 1;
		release_chk();
		err_event_in = 1;
		step(1);
		err_event_in = 0;
		hub_req = 1;
		step(4 + $urandom_range(6));
		chk("hard", {sticky_err_out, hard_reset_out, cpu_bus_reset_out_n}, 4'hc);
		chk("ports", port_reset_out, 4'hf);
		hub_req = 0;
		release_chk();
		cfg_hard_req_in = 1;
		step(5);
		chk("cfg_hard", {sticky_err_out, hard_reset_out, link_train_en_out[0]}, 4'h6);
		cfg_hard_req_in = 0;
		step(40);
		cfg_cpu_req_in = 1;
		step(4);
		chk("cpu_only", {core_reset_out, hard_reset_out, cpu_bus_reset_out_n}, 0);
		cfg_cpu_req_in = 0;
		cfg_port_req_in = 4'($urandom_range(15, 1));
		step(4);
		chk("target", port_reset_out, cfg_port_req_in);
		cfg_port_req_in = 0;
		bus_init_n_in = 0;
		step(4);
		chk("bus_init_n", {in_order_queue_clr_out, refresh_en_out, bus_init_n_seen_out, |port_reset_out}, 4'he);
		chk("bus_sm", bus_sm_reset_out, 1);
		bus_init_n_in = 1;
		for (int s = 0; s < 8; s++) begin
			sleep_req_in = 3'(s);
			sleep_req_valid_in = 1;
			step(1);
			sleep_req_valid_in = 0;
			chk("reject", sleep_reject_out, 4'(s == 2 || s > 5));
			step(1);
		end
		chk("sleep_state", sleep_state_out, 5);
		supply_ok = 0;
		step(2);
		chk("pg_off", {core_reset_out, sticky_err_out, cpu_bus_reset_out_n}, 4'h8);
		end_sim();
	end
	initial begin
		#40000;
		fail_count++;
		end_sim();
	end
endmodule
bind hrcc_top hrcc_asserts #(.CPU_HOLD_CYC(CPU_HOLD_CYC), .NPORT(NPORT), .NCPU(NCPU)) i_hrcc_asserts (.*);
